// file: common/mb_pkg.sv
`default_nettype none
package mb_pkg;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] FC_WR_SINGLE = 8'h06;
  localparam logic [7:0] FC_WR_MULTI = 8'h10;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [15:0] MULTI_QTY_MAX = 16'h007B;
  localparam logic [15:0] READ_QTY_MAX = 16'h007D;
  localparam logic [7:0] SHORT_REQ_LEN = 8'h08;
  localparam logic [8:0] MULTI_HDR_LEN = 9'h009;
  localparam logic [7:0] ECHO_LEN = 8'h06;
  localparam logic [7:0] EXC_LEN = 8'h03;
  // device register map, register addresses counted from zero
  localparam logic [15:0] REG_POSITION = 16'h0001;
  localparam logic [15:0] REG_ALARM = 16'h0002;
  localparam logic [15:0] REG_OP_CFG = 16'h0003;
  localparam logic [15:0] REG_NODE_ID = 16'h0004;
  localparam logic [15:0] REG_LINE_SPEED = 16'h0005;
  localparam logic [15:0] REG_COMMAND = 16'h000A;
  localparam int OPC_SCALE_BIT = 0;
  localparam int OPC_DIR_BIT = 1;
  localparam logic [15:0] OPC_USED_MASK = 16'h0003;
  localparam int CMD_WD_BIT = 0;
  localparam logic [7:0] NODE_RESET = 8'h01;
  localparam logic [15:0] SPEED_RESET = 16'h0001;
  localparam logic [15:0] SPEED_9600_EVEN = 16'h0001;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned WD_TIMEOUT_S = 1;
  localparam int unsigned WD_CYCLES = WD_TIMEOUT_S * CLK_HZ;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  // client end registers on the bus
  localparam logic [7:0] CL_TXDATA = 8'h00;
  localparam logic [7:0] CL_RXDATA = 8'h04;
  localparam logic [7:0] CL_STATUS = 8'h08;
  localparam logic [7:0] CL_MASK = 8'h0C;
  localparam int TX_LAST_BIT = 8;
  localparam int RX_LAST_BIT = 8;
  localparam int RX_VALID_BIT = 9;
  localparam int RX_TXFULL_BIT = 10;
  localparam int ST_RX_BYTE = 0;
  localparam int ST_FRAME_OK = 1;
  localparam int ST_FRAME_BAD = 2;
  localparam int ST_OVERRUN = 3;

  function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc16_step
endpackage : mb_pkg
`default_nettype wire

// file: common/mb_link.sv
`timescale 1ns/100ps
`default_nettype none
interface mb_link;
  logic [7:0] req_data;
  logic req_valid;
  logic req_last;
  logic req_ready;
  logic [7:0] rsp_data;
  logic rsp_valid;
  logic rsp_last;
  modport device(input req_data, req_valid, req_last,
                 output req_ready, rsp_data, rsp_valid, rsp_last);
  modport client(output req_data, req_valid, req_last,
                 input req_ready, rsp_data, rsp_valid, rsp_last);
endinterface : mb_link
`default_nettype wire

// file: hw/mb_slave_end.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - single write: function, address, value; zero-based
// - write register first, then echo request
// - single write failure: 86 hex plus code
// - multi write 10 hex covers 1..123 registers
// - multi write: start, quantity, byte count, data
// - multi write reply: function, start, quantity
// - multi write failure: 90 hex plus code
// - input read reply: address, function, count, data
// - reply carries newly stored node address
// - config bit0 scaling, bit1 direction, rest zero
// - speed value 1 means 9600 even parity
// - command bit0 switches the watchdog
// - one second silence forces alarm, reported later
// - master keeps talking continuously
// - drop frames for other node addresses
// - function zero invalid, 128..255 exceptions only
module mb_slave_end import mb_pkg::*; #(
  parameter int unsigned WD_LIMIT = WD_CYCLES,
  parameter int BUF_DEPTH = 256
) (
  input wire logic hclk,
  input wire logic hresetn,
  mb_link.device link,
  input wire logic [15:0] position,
  output logic scaling_en,
  output logic count_down,
  output logic [15:0] line_speed,
  output logic wd_alarm
);
  typedef enum logic [3:0] {
    S_RX = 4'b0001, S_EXEC = 4'b0010, S_WRITE = 4'b0100, S_TX = 4'b1000
  } st_e;
  st_e st_q, st_d;
  logic [7:0] buf_q [BUF_DEPTH];
  logic [7:0] len_q, tx_len_q, tx_idx_q, exc_q, exc_d, active_node_q, tx_byte;
  logic [15:0] crc_q, tx_crc_q, op_cfg_q, node_id_q, speed_q, cmd_q, speed_act_q;
  logic [15:0] fa, fq, wr_addr, wr_val, rd_word;
  logic [6:0] wi_q;
  logic ovf_q, alarm_q, rdy_q, rv_q, rl_q, frame_ok, acc, wr_en, tx_end;
  logic [7:0] rd_q;
  logic [31:0] wd_cnt_q;
  logic [16:0] a_end;

  ////////////////////////////////////////////////////////////////////////////
  assign fa = {buf_q[2], buf_q[3]};
  assign fq = {buf_q[4], buf_q[5]};
  assign a_end = {1'b0, fa} + {1'b0, fq};
  assign acc = link.req_valid && st_q == S_RX;
  assign frame_ok = crc_q == 16'h0000 && !ovf_q && len_q >= 8'h04 &&
                    buf_q[0] == active_node_q && !buf_q[1][7];
  assign tx_end = st_q == S_TX && tx_idx_q == tx_len_q + 8'h01;
  assign link.req_ready = rdy_q;
  assign link.rsp_data = rd_q;
  assign link.rsp_valid = rv_q;
  assign link.rsp_last = rl_q;
  assign scaling_en = op_cfg_q[OPC_SCALE_BIT];
  assign count_down = op_cfg_q[OPC_DIR_BIT];
  assign line_speed = speed_act_q;
  assign wd_alarm = alarm_q;

  ////////////////////////////////////////////////////////////////////////////
  // request checks, exception code zero means accepted
  always_comb begin
    exc_d = 8'h00;
    case (buf_q[1])
      FC_RD_INPUT: begin
        if (len_q != SHORT_REQ_LEN || fq == 16'h0000 || fq > READ_QTY_MAX) begin
          exc_d = EXC_VALUE;
        end else if (fa < REG_POSITION || a_end > {1'b0, REG_ALARM} + 17'h00001) begin
          exc_d = EXC_ADDR;
        end
      end
      FC_WR_SINGLE: begin
        if (len_q != SHORT_REQ_LEN) begin
          exc_d = EXC_VALUE;
        end else if (!(fa == REG_OP_CFG || fa == REG_NODE_ID || fa == REG_LINE_SPEED ||
                       fa == REG_COMMAND)) begin
          exc_d = EXC_ADDR;
        end
      end
      FC_WR_MULTI: begin
        if (fq == 16'h0000 || fq > MULTI_QTY_MAX || {8'h00, buf_q[6]} != {fq[14:0], 1'b0} ||
            {1'b0, len_q} != MULTI_HDR_LEN + {1'b0, buf_q[6]}) begin
          exc_d = EXC_VALUE;
        end else if (!((fa >= REG_OP_CFG && a_end <= {1'b0, REG_LINE_SPEED} + 17'h00001) ||
                       (fa == REG_COMMAND && fq == 16'h0001))) begin
          exc_d = EXC_ADDR;
        end
      end
      default: exc_d = EXC_FUNC;
    endcase
  end

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      S_RX: if (acc && link.req_last) st_d = S_EXEC;
      S_EXEC: begin
        if (!frame_ok) begin
          st_d = S_RX;
        end else if (buf_q[1] == FC_WR_MULTI && exc_d == 8'h00) begin
          st_d = S_WRITE;
        end else begin
          st_d = S_TX;
        end
      end
      S_WRITE: if ({9'h000, wi_q} == fq - 16'h0001) st_d = S_TX;
      S_TX: if (tx_end) st_d = S_RX;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= S_RX;
      rdy_q <= 1'b1;
    end else begin
      st_q <= st_d;
      rdy_q <= st_d == S_RX;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive buffer with running check value
  always_ff @(posedge hclk) begin
    if (acc) begin
      buf_q[len_q] <= link.req_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      len_q <= 8'h00;
      ovf_q <= 1'b0;
      crc_q <= CRC_INIT;
    end else if (st_q == S_RX) begin
      if (acc) begin
        crc_q <= crc16_step(crc_q, link.req_data);
        if (len_q == 8'hFF) begin
          ovf_q <= 1'b1;
        end else begin
          len_q <= len_q + 8'h01;
        end
      end
    end else if (st_d == S_RX) begin
      len_q <= 8'h00;
      ovf_q <= 1'b0;
      crc_q <= CRC_INIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes happen before the reply starts
  always_comb begin
    wr_en = 1'b0;
    wr_addr = fa;
    wr_val = fq;
    if (st_q == S_EXEC && frame_ok && buf_q[1] == FC_WR_SINGLE && exc_d == 8'h00) begin
      wr_en = 1'b1;
    end else if (st_q == S_WRITE) begin
      wr_en = 1'b1;
      wr_addr = fa + {9'h000, wi_q};
      wr_val = {buf_q[8'(7 + 2 * wi_q)], buf_q[8'(8 + 2 * wi_q)]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wi_q <= 7'h00;
    end else begin
      wi_q <= (st_q == S_WRITE) ? wi_q + 7'h01 : 7'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_cfg_q <= 16'h0000;
      node_id_q <= {8'h00, NODE_RESET};
      speed_q <= SPEED_RESET;
      cmd_q <= 16'h0000;
    end else if (wr_en) begin
      unique case (wr_addr)
        REG_OP_CFG: op_cfg_q <= wr_val & OPC_USED_MASK;
        REG_NODE_ID: node_id_q <= wr_val;
        REG_LINE_SPEED: speed_q <= wr_val;
        REG_COMMAND: cmd_q <= wr_val;
        default: ;
      endcase
    end
  end

  // address and speed in use change only once the reply is out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_node_q <= NODE_RESET;
      speed_act_q <= SPEED_RESET;
    end else if (tx_end) begin
      active_node_q <= node_id_q[7:0];
      speed_act_q <= speed_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // supervision of the master, which must keep polling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_cnt_q <= 32'h0000_0000;
      alarm_q <= 1'b0;
    end else begin
      if (!cmd_q[CMD_WD_BIT]) begin
        wd_cnt_q <= wd_cnt_q;
      end else if (st_q == S_EXEC && frame_ok) begin
        wd_cnt_q <= 32'h0000_0000;
      end else if (wd_cnt_q >= WD_LIMIT - 1) begin
        wd_cnt_q <= 32'h0000_0000;
      end else begin
        wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
      end
      if (cmd_q[CMD_WD_BIT] && wd_cnt_q >= WD_LIMIT - 1) begin
        alarm_q <= 1'b1;
      end else if (wr_en && wr_addr == REG_COMMAND) begin
        alarm_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply assembly
  // register of a data byte pair is (tx_idx_q - 3) / 2 past the start
  assign rd_word = (fa + {8'h00, 1'b0, tx_idx_q[7:1]} - 16'h0001 - {15'h0000, !tx_idx_q[0]} ==
                    REG_POSITION) ? position : {15'h0000, alarm_q};

  always_comb begin
    if (tx_idx_q == tx_len_q) begin
      tx_byte = tx_crc_q[7:0];
    end else if (tx_idx_q == tx_len_q + 8'h01) begin
      tx_byte = tx_crc_q[15:8];
    end else if (tx_idx_q == 8'h00) begin
      tx_byte = node_id_q[7:0];
    end else if (exc_q != 8'h00) begin
      tx_byte = (tx_idx_q == 8'h01) ? (buf_q[1] | FC_EXC_FLAG) : exc_q;
    end else if (buf_q[1] == FC_RD_INPUT && tx_idx_q == 8'h02) begin
      tx_byte = {fq[6:0], 1'b0};
    end else if (buf_q[1] == FC_RD_INPUT && tx_idx_q > 8'h02) begin
      tx_byte = tx_idx_q[0] ? rd_word[15:8] : rd_word[7:0];
    end else begin
      tx_byte = buf_q[tx_idx_q];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exc_q <= 8'h00;
      tx_len_q <= 8'h00;
    end else if (st_q == S_EXEC) begin
      exc_q <= exc_d;
      if (exc_d != 8'h00) begin
        tx_len_q <= EXC_LEN;
      end else if (buf_q[1] == FC_RD_INPUT) begin
        tx_len_q <= 8'h03 + {fq[6:0], 1'b0};
      end else begin
        tx_len_q <= ECHO_LEN;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_idx_q <= 8'h00;
      tx_crc_q <= CRC_INIT;
      rd_q <= 8'h00;
      rv_q <= 1'b0;
      rl_q <= 1'b0;
    end else if (st_q == S_TX) begin
      rd_q <= tx_byte;
      rv_q <= 1'b1;
      rl_q <= tx_end;
      tx_idx_q <= tx_end ? 8'h00 : tx_idx_q + 8'h01;
      if (tx_idx_q < tx_len_q) begin
        tx_crc_q <= crc16_step(tx_crc_q, tx_byte);
      end else if (tx_end) begin
        tx_crc_q <= CRC_INIT;
      end
    end else begin
      rv_q <= 1'b0;
      rl_q <= 1'b0;
      rd_q <= 8'h00;
    end
  end
endmodule : mb_slave_end
`default_nettype wire

// file: hw/mb_client_end.sv
`timescale 1ns/100ps
`default_nettype none
module mb_client_end import mb_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq,
  mb_link.client link
);
  logic acc, acc_tx, dp_tx_q, dp_wr_q, hr_q, load, take, tx_full_q, tx_full_d, irq_q;
  logic rx_valid_q, rx_last_q;
  logic [1:0] phase_q;
  logic [7:0] dp_addr_q, tx_data_q, rx_data_q;
  logic [15:0] tx_crc_q, rx_crc_q, rx_crc_d;
  logic [3:0] status_q, status_set, mask_q;
  logic [31:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  assign acc = hsel && hready && htrans[1];
  assign acc_tx = acc && hwrite && haddr[7:0] == CL_TXDATA;
  assign load = dp_tx_q && hr_q;
  assign take = tx_full_q && link.req_ready;
  // the slot frees after a non-final user byte or the final check byte, not after the last user byte or between check bytes
  assign tx_full_d = (tx_full_q && !(take && (phase_q == 2'd0 || phase_q == 2'd2))) || load;
  assign hreadyout = hr_q;
  assign hrdata = rdata_q;
  assign hresp = 1'b0;
  assign irq = irq_q;
  assign link.req_valid = tx_full_q;
  assign link.req_data = tx_data_q;
  assign link.req_last = phase_q == 2'd2;

  // a write to the transmit slot waits while the slot is still occupied
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hr_q <= 1'b1;
      dp_tx_q <= 1'b0;
      dp_wr_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end else begin
      hr_q <= !((acc_tx || (dp_tx_q && !hr_q)) && tx_full_d);
      if (acc) begin
        dp_tx_q <= acc_tx;
        dp_wr_q <= hwrite;
        dp_addr_q <= haddr[7:0];
      end else if (hr_q) begin
        dp_tx_q <= 1'b0;
        dp_wr_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      unique case (haddr[7:0])
        CL_RXDATA: rdata_q <= {21'h000000, tx_full_q, rx_valid_q, rx_last_q, rx_data_q};
        CL_STATUS: rdata_q <= {28'h0000000, status_q};
        CL_MASK: rdata_q <= {28'h0000000, mask_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outgoing frame: user bytes, then check value low byte then high byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_full_q <= 1'b0;
      phase_q <= 2'd0;
      tx_data_q <= 8'h00;
      tx_crc_q <= CRC_INIT;
    end else begin
      tx_full_q <= tx_full_d;
      if (load) begin
        tx_data_q <= hwdata[7:0];
        phase_q <= hwdata[TX_LAST_BIT] ? 2'd3 : 2'd0;
      end else if (take) begin
        unique case (phase_q)
          2'd0: tx_crc_q <= crc16_step(tx_crc_q, tx_data_q);
          2'd3: begin
            tx_data_q <= 8'(crc16_step(tx_crc_q, tx_data_q));
            tx_crc_q <= crc16_step(tx_crc_q, tx_data_q);
            phase_q <= 2'd1;
            tx_full_q <= 1'b1;
          end
          2'd1: begin
            tx_data_q <= tx_crc_q[15:8];
            phase_q <= 2'd2;
            tx_full_q <= 1'b1;
          end
          2'd2: begin
            phase_q <= 2'd0;
            tx_crc_q <= CRC_INIT;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // incoming reply bytes and sticky events
  assign rx_crc_d = crc16_step(rx_crc_q, link.rsp_data);

  always_comb begin
    status_set = 4'h0;
    status_set[ST_RX_BYTE] = link.rsp_valid;
    status_set[ST_FRAME_OK] = link.rsp_valid && link.rsp_last && rx_crc_d == 16'h0000;
    status_set[ST_FRAME_BAD] = link.rsp_valid && link.rsp_last && rx_crc_d != 16'h0000;
    status_set[ST_OVERRUN] = link.rsp_valid && rx_valid_q &&
                             !(acc && !hwrite && haddr[7:0] == CL_RXDATA);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_valid_q <= 1'b0;
      rx_last_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_crc_q <= CRC_INIT;
    end else if (link.rsp_valid) begin
      rx_valid_q <= 1'b1;
      rx_last_q <= link.rsp_last;
      rx_data_q <= link.rsp_data;
      rx_crc_q <= link.rsp_last ? CRC_INIT : rx_crc_d;
    end else if (acc && !hwrite && haddr[7:0] == CL_RXDATA) begin
      rx_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= 4'h0;
      mask_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      if (dp_wr_q && hr_q && dp_addr_q == CL_STATUS) begin
        status_q <= (status_q & ~hwdata[3:0]) | status_set;
      end else begin
        status_q <= status_q | status_set;
      end
      if (dp_wr_q && hr_q && dp_addr_q == CL_MASK) begin
        mask_q <= hwdata[3:0];
      end
      irq_q <= |(status_q & mask_q);
    end
  end
endmodule : mb_client_end
`default_nettype wire

// file: verification/modbus_register_write_handler_properties.sv
`timescale 1ns/100ps
`default_nettype none
module modbus_register_write_handler_properties import mb_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] req_data,
  input wire logic req_valid,
  input wire logic req_last,
  input wire logic req_ready,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_valid,
  input wire logic rsp_last
);
  logic [8:0] idx_q;
  logic [7:0] fc_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // position of the next byte inside the reply, 1 is the function byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) idx_q <= 9'h000;
    else if (rsp_valid) idx_q <= rsp_last ? 9'h000 : idx_q + 9'h001;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) fc_q <= 8'h00;
    else if (rsp_valid && idx_q == 9'h001) fc_q <= rsp_data;
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_head(logic [7:0] fc);
    rsp_valid && idx_q == 9'h001 && rsp_data == fc;
  endsequence
  sequence s_exc_head;
    rsp_valid && idx_q == 9'h001 && rsp_data[7];
  endsequence
  sequence s_taken_last;
    req_valid && req_ready && req_last;
  endsequence
  property p_hold;
    req_valid && !req_ready |=> req_valid && $stable(req_data) && $stable(req_last);
  endproperty
  property p_busy;
    rsp_valid && !rsp_last |-> !req_ready;
  endproperty
  property p_last;
    rsp_last |-> rsp_valid;
  endproperty
  property p_burst;
    rsp_valid && !rsp_last |=> rsp_valid;
  endproperty
  property p_echo_len;
    s_head(FC_WR_SINGLE) |-> ##6 (rsp_valid && rsp_last);
  endproperty
  property p_multi_len;
    s_head(FC_WR_MULTI) |-> ##6 (rsp_valid && rsp_last);
  endproperty
  property p_exc;
    s_exc_head |=> rsp_data inside {[8'h01:8'h04]} ##2 (rsp_valid && rsp_last);
  endproperty
  property p_fc_valid;
    rsp_valid && idx_q == 9'h001 |-> rsp_data != 8'h00;
  endproperty
  property p_read_count;
    rsp_valid && idx_q == 9'h002 && fc_q == FC_RD_INPUT |-> rsp_data != 8'h00 && !rsp_data[0];
  endproperty
  property p_exec;
    s_taken_last |=> !req_ready ##[0:1000] req_ready;
  endproperty
  a_hold: assert property (p_hold) else $error("request changed before taken");
  a_busy: assert property (p_busy) else $error("ready during reply");
  a_last: assert property (p_last) else $error("last without valid");
  a_burst: assert property (p_burst) else $error("reply bytes not back to back");
  a_echo_len: assert property (p_echo_len) else $error("echo length wrong");
  a_multi_len: assert property (p_multi_len) else $error("multi reply length wrong");
  a_exc: assert property (p_exc) else $error("exception reply malformed");
  a_fc_valid: assert property (p_fc_valid) else $error("function zero in reply");
  a_read_count: assert property (p_read_count) else $error("read byte count odd");
  a_exec: assert property (p_exec) else $error("request end handling wrong");
endmodule : modbus_register_write_handler_properties
`default_nettype wire

// file: verification/modbus_register_write_handler_test.sv
`timescale 1ns/100ps
`default_nettype none
module modbus_register_write_handler_test import mb_pkg::*; ;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] position = 16'h0;
  logic hreadyout, hresp, irq, scaling_en, count_down, wd_alarm;
  logic [31:0] hrdata, rd_v;
  logic [15:0] line_speed;
  logic [31:0] seed = 32'h67E70920;
  logic [8:0] exp_q[$];
  logic [7:0] none[$];
  int miscompares = 0;
  int n_checks = 0;
  mb_link link();
  mb_slave_end #(.WD_LIMIT(200)) i_mb_slave_end (.hclk(hclk), .hresetn(hresetn), .link(link),
    .position(position), .scaling_en(scaling_en), .count_down(count_down),
    .line_speed(line_speed), .wd_alarm(wd_alarm));
  mb_client_end i_mb_client_end (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq), .link(link));
  modbus_register_write_handler_properties i_modbus_register_write_handler_properties (
    .hclk(hclk), .hresetn(hresetn), .req_data(link.req_data), .req_valid(link.req_valid),
    .req_last(link.req_last), .req_ready(link.req_ready), .rsp_data(link.rsp_data),
    .rsp_valid(link.rsp_valid), .rsp_last(link.rsp_last));
  initial begin
    forever #5 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [15:0] crc_of(input logic [7:0] f[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_of
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  task automatic fail_out(input string msg);
    chk(1'b0, msg);
    give_verdict();
  endtask : fail_out
  // one single transfer: address phase, then data phase, each held until hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(negedge hclk);
        n++;
      end while (hreadyout !== 1'b1 && n < 500);
      if (n >= 500) fail_out("bus wait timeout");
      r = hrdata;
      @(posedge hclk);
      if (p == 0) begin
        htrans <= 2'h0;
        hwdata <= d;
      end
    end
  endtask : ahb
  // note the expected reply with its check bytes, send the request, wait for quiet
  task automatic xfer(input logic [7:0] rq[$], input logic [7:0] rs[$]);
    logic [15:0] c;
    int n;
    int idle;
    if (rs.size() > 0) begin
      c = crc_of(rs);
      rs.push_back(c[7:0]);
      rs.push_back(c[15:8]);
      foreach (rs[i]) exp_q.push_back({i == rs.size() - 1, rs[i]});
    end
    foreach (rq[i]) ahb(1'b1, CL_TXDATA, {23'h0, i == rq.size() - 1, rq[i]}, rd_v);
    idle = 0;
    n = 0;
    while (idle < 6 && n < 3000) begin
      @(negedge hclk);
      n++;
      idle = (exp_q.size() == 0 && link.req_ready === 1'b1 && link.req_valid === 1'b0) ?
             idle + 1 : 0;
    end
    if (n >= 3000) fail_out("reply wait timeout");
    @(posedge hclk);
  endtask : xfer
  task automatic exc(input logic [7:0] rq[$], input logic [7:0] code);
    xfer(rq, '{rq[0], rq[1] | FC_EXC_FLAG, code});
  endtask : exc
  always @(negedge hclk) begin
    if (hresetn === 1'b1 && link.rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected reply byte");
      else chk({link.rsp_last, link.rsp_data} === exp_q.pop_front(), "reply byte");
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic [7:0] fr[$];
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk(scaling_en === 1'b0 && count_down === 1'b0 && wd_alarm === 1'b0, "reset");
    chk(line_speed === SPEED_RESET && irq === 1'b0, "reset speed");
    @(posedge hclk);
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      fr = '{8'h01, FC_WR_SINGLE, 8'h00, 8'h03, 8'h00, {6'h00, v[1:0]}};
      xfer(fr, fr);
      chk(scaling_en === v[0] && count_down === v[1], "config bits");
    end
    v = rnd();
    position <= v[15:0];
    fr = '{8'h01, FC_RD_INPUT, 8'h00, 8'h01, 8'h00, 8'h02};
    xfer(fr, '{8'h01, FC_RD_INPUT, 8'h04, v[15:8], v[7:0], 8'h00, 8'h00});
    $display("test write and read done");
    exc('{8'h01, FC_WR_SINGLE, 8'h00, 8'h07, 8'h00, 8'h00}, EXC_ADDR);
    exc('{8'h01, 8'h00, 8'h00, 8'h01}, EXC_FUNC);
    exc('{8'h01, 8'h2B, 8'h00, 8'h01}, EXC_FUNC);
    exc('{8'h01, FC_WR_MULTI, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00}, EXC_VALUE);
    exc('{8'h01, FC_WR_MULTI, 8'h00, 8'h03, 8'h00, 8'h7C, 8'hF8}, EXC_VALUE);
    fr = '{8'h01, FC_WR_MULTI, 8'h00, 8'h03, 8'h00, 8'h02, 8'h03, 8'h00, 8'h00, 8'h00};
    exc(fr, EXC_VALUE);
    exc('{8'h01, FC_WR_MULTI, 8'h00, 8'h06, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00}, EXC_ADDR);
    xfer('{8'h01, 8'h86, 8'h00, 8'h03, 8'h00, 8'h01}, none);
    $display("test exceptions done");
    fr = '{8'h01, FC_WR_MULTI, 8'h00, 8'h04, 8'h00, 8'h02, 8'h04, 8'h00, 8'h0A, 8'h00, 8'h01};
    xfer(fr, '{8'h0A, FC_WR_MULTI, 8'h00, 8'h04, 8'h00, 8'h02});
    chk(line_speed === SPEED_9600_EVEN, "line speed");
    xfer('{8'h01, FC_RD_INPUT, 8'h00, 8'h01, 8'h00, 8'h01}, none);
    fr = '{8'h0A, FC_WR_MULTI, 8'h00, 8'h03, 8'h00, 8'h03, 8'h06,
           8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01};
    xfer(fr, '{8'h01, FC_WR_MULTI, 8'h00, 8'h03, 8'h00, 8'h03});
    chk(scaling_en === 1'b1 && count_down === 1'b0, "multi config");
    $display("test node change done");
    ahb(1'b0, CL_STATUS, 32'h0, v);
    chk(v[ST_FRAME_OK] === 1'b1 && irq === 1'b0, "status masked");
    ahb(1'b1, CL_MASK, 32'h2, v);
    repeat (2) @(negedge hclk);
    chk(irq === 1'b1, "irq raised");
    @(posedge hclk);
    ahb(1'b1, CL_STATUS, 32'h2, v);
    repeat (2) @(negedge hclk);
    chk(irq === 1'b0, "irq cleared");
    @(posedge hclk);
    ahb(1'b0, 8'h10, 32'h0, v);
    chk(v === 32'h0, "unmapped read");
    $display("test interrupt done");
    fr = '{8'h01, FC_WR_SINGLE, 8'h00, 8'h0A, 8'h00, 8'h01};
    xfer(fr, fr);
    fr = '{8'h01, FC_RD_INPUT, 8'h00, 8'h02, 8'h00, 8'h01};
    for (int i = 0; i < 3; i++) begin
      repeat (100) @(posedge hclk);
      xfer(fr, '{8'h01, FC_RD_INPUT, 8'h02, 8'h00, 8'h00});
    end
    chk(wd_alarm === 1'b0, "kept alive");
    repeat (250) @(posedge hclk);
    chk(wd_alarm === 1'b1, "silence alarm");
    xfer(fr, '{8'h01, FC_RD_INPUT, 8'h02, 8'h00, 8'h01});
    fr = '{8'h01, FC_WR_SINGLE, 8'h00, 8'h0A, 8'h00, 8'h00};
    xfer(fr, fr);
    repeat (250) @(posedge hclk);
    chk(wd_alarm === 1'b0, "watchdog off");
    $display("test watchdog done");
    give_verdict();
  end
endmodule : modbus_register_write_handler_test
`default_nettype wire
